// ### design/cpt_pkg.sv
package cpt_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int PRIO_LEVEL_W = 3;
  localparam int CPU_PRIO_W = 4;

  // register offsets (byte addresses, one 16-bit word each)
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_CORE = 8'h02;
  localparam logic [7:0] OFS_TRAP = 8'h04;
  localparam logic [7:0] OFS_EVT_STATUS = 8'h06;
  localparam logic [7:0] OFS_EVT_MASK = 8'h08;
  localparam logic [7:0] OFS_PRIO_BASE = 8'h10;
  localparam int PRIO_STRIDE = 2;

  // cpu_status_word fields
  localparam int BIT_PRIO_LOW = 5;

  // core_control_word fields
  localparam int BIT_PRIO_HIGH = 3;

  // trap_and_nesting_control fields
  localparam int BIT_NEST_DIS = 15;
  localparam int BIT_OVF_A = 14;
  localparam int BIT_OVF_B = 13;
  localparam int BIT_CAT_A = 12;
  localparam int BIT_CAT_B = 11;
  localparam int BIT_OVF_A_EN = 10;
  localparam int BIT_OVF_B_EN = 9;
  localparam int BIT_CAT_EN = 8;
  localparam int BIT_SHIFT = 7;
  localparam int BIT_DIV0 = 6;
  localparam int BIT_DMA = 5;
  localparam int BIT_MATH = 4;
  localparam logic [15:0] TRAP_FLAG_MASK = 16'h78F0;
  localparam logic [15:0] TRAP_CTRL_MASK = 16'h8700;

  // event status / mask layout
  localparam int EVT_W = 2;
  localparam int EVT_MATH = 0;
  localparam int EVT_DMA = 1;

  // values after reset
  localparam logic [2:0] RST_PRIO_LOW = 3'h0;
  localparam logic RST_PRIO_HIGH = 1'b0;
  localparam logic [15:0] RST_TRAP = 16'h0000;
  localparam logic [1:0] RST_EVT = 2'h0;
  localparam logic [2:0] RST_SRC_PRIO = 3'h0;
  localparam logic [15:0] RST_RDATA = 16'h0000;

endpackage

// ### design/cpt_arb_if.sv
`timescale 1ns/1ps
interface cpt_arb_if #(
  parameter int NUM_SRC = 8
);
  import cpt_pkg::*;
  localparam int ID_W = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1;

  logic [NUM_SRC-1:0] pending;
  logic [PRIO_LEVEL_W*NUM_SRC-1:0] prio_flat;
  logic best_valid;
  logic [ID_W-1:0] best_id;
  logic [PRIO_LEVEL_W-1:0] best_level;

  modport ctrl (
    output pending,
    output prio_flat,
    input best_valid,
    input best_id,
    input best_level
  );

  modport arb (
    input pending,
    input prio_flat,
    output best_valid,
    output best_id,
    output best_level
  );
endinterface

// ### design/cpt_src_arbiter.sv
`timescale 1ns/1ps
// picks the pending user source with the highest assigned level;
// on a tie the lower source index wins
module cpt_src_arbiter
  import cpt_pkg::*;
#(
  parameter int NUM_SRC = 8
) (
  cpt_arb_if.arb a
);
  localparam int ID_W = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1;

  always_comb begin
    a.best_valid = 1'b0;
    a.best_id = '0;
    a.best_level = '0;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (a.pending[i] && (!a.best_valid || a.prio_flat[PRIO_LEVEL_W*i +: PRIO_LEVEL_W] > a.best_level)) begin
        a.best_valid = 1'b1;
        a.best_id = ID_W'(i);
        a.best_level = a.prio_flat[PRIO_LEVEL_W*i +: PRIO_LEVEL_W];
      end
    end
  end
endmodule

// ### design/cpt_priority_trap.sv
`timescale 1ns/1ps
// Function
// - three-bit priority field in status bits 7:5
// - effective priority is high bit above field
// - high bit set blocks all user interrupts
// - nesting disable makes priority field read-only
// - core bit 3 shows priority above 7
// - nesting disable stops preemption of serviced interrupt
// - flag accumulator A/B overflow traps, bits 14/13
// - flag catastrophic A/B overflow traps, bits 12/11
// - bits 10/9 enable ordinary overflow traps
// - bit 8 enables catastrophic overflow traps
// - bit 7 flags invalid shift math trap
// - bit 6 flags divide by zero trap
// - bit 5 flags DMA controller fault trap
// - bit 4 flags any math error trap
// - high priority bit never set by software
// - each user source gets one of eight levels
module cpt_priority_trap
  import cpt_pkg::*;
#(
  parameter int NUM_SRC = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic core_priority_load,
  input wire logic [CPU_PRIO_W-1:0] core_priority_value,
  input wire logic core_in_service,
  input wire logic acc_a_overflow,
  input wire logic acc_b_overflow,
  input wire logic acc_a_catastrophic,
  input wire logic acc_b_catastrophic,
  input wire logic bad_shift_event,
  input wire logic divide_zero_event,
  input wire logic dma_fault_event,
  input wire logic [NUM_SRC-1:0] user_irq_pending,
  output logic [CPU_PRIO_W-1:0] cpu_priority,
  output logic nesting_disable,
  output logic irq_take,
  output logic [((NUM_SRC > 1) ? $clog2(NUM_SRC) : 1)-1:0] irq_take_id,
  output logic [PRIO_LEVEL_W-1:0] irq_take_level,
  output logic math_trap,
  output logic dma_trap,
  output logic irq
);
  localparam int ID_W = (NUM_SRC > 1) ? $clog2(NUM_SRC) : 1;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] ofs);
    reg_hit = (addr == ofs);
  endfunction

  function automatic logic [ADDR_W-1:0] prio_ofs(input int idx);
    prio_ofs = ADDR_W'(int'(OFS_PRIO_BASE) + PRIO_STRIDE * idx);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register bus decode

  logic wr_status;
  logic wr_core;
  logic wr_trap;
  logic wr_evt_status;
  logic wr_evt_mask;

  assign wr_status = reg_wr && reg_hit(reg_addr, OFS_STATUS);
  assign wr_core = reg_wr && reg_hit(reg_addr, OFS_CORE);
  assign wr_trap = reg_wr && reg_hit(reg_addr, OFS_TRAP);
  assign wr_evt_status = reg_wr && reg_hit(reg_addr, OFS_EVT_STATUS);
  assign wr_evt_mask = reg_wr && reg_hit(reg_addr, OFS_EVT_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // cpu priority

  logic [PRIO_LEVEL_W-1:0] cpu_priority_low;
  logic cpu_priority_high_bit;
  logic [DATA_W-1:0] trap_ctl;
  logic nest_dis;

  assign nest_dis = trap_ctl[BIT_NEST_DIS];

  // the core's own load (interrupt entry or return) outranks a software write
  always_ff @(posedge clk) begin
    if (reset) begin
      cpu_priority_low <= RST_PRIO_LOW;
    end else if (core_priority_load) begin
      cpu_priority_low <= core_priority_value[PRIO_LEVEL_W-1:0];
    end else if (wr_status && !nest_dis) begin
      cpu_priority_low <= reg_wdata[BIT_PRIO_LOW +: PRIO_LEVEL_W];
    end
  end

  // software may only clear the high bit, so code cannot raise cpu priority above 7
  always_ff @(posedge clk) begin
    if (reset) begin
      cpu_priority_high_bit <= RST_PRIO_HIGH;
    end else if (core_priority_load) begin
      cpu_priority_high_bit <= core_priority_value[CPU_PRIO_W-1];
    end else if (wr_core && !reg_wdata[BIT_PRIO_HIGH]) begin
      cpu_priority_high_bit <= 1'b0;
    end
  end

  logic [CPU_PRIO_W-1:0] eff_priority;
  assign eff_priority = {cpu_priority_high_bit, cpu_priority_low};

  ////////////////////////////////////////////////////////////////////////////
  // trap causes

  logic ovf_a_trap;
  logic ovf_b_trap;
  logic cat_a_trap;
  logic cat_b_trap;
  logic any_math_trap;
  logic [DATA_W-1:0] trap_set;
  logic [DATA_W-1:0] next_trap_ctl;

  assign ovf_a_trap = acc_a_overflow && trap_ctl[BIT_OVF_A_EN];
  assign ovf_b_trap = acc_b_overflow && trap_ctl[BIT_OVF_B_EN];
  assign cat_a_trap = acc_a_catastrophic && trap_ctl[BIT_CAT_EN];
  assign cat_b_trap = acc_b_catastrophic && trap_ctl[BIT_CAT_EN];
  // accumulator overflows count as math errors alongside shift and divide faults
  assign any_math_trap = ovf_a_trap || ovf_b_trap || cat_a_trap || cat_b_trap
    || bad_shift_event || divide_zero_event;

  always_comb begin
    trap_set = '0;
    trap_set[BIT_OVF_A] = ovf_a_trap;
    trap_set[BIT_OVF_B] = ovf_b_trap;
    trap_set[BIT_CAT_A] = cat_a_trap;
    trap_set[BIT_CAT_B] = cat_b_trap;
    trap_set[BIT_SHIFT] = bad_shift_event;
    trap_set[BIT_DIV0] = divide_zero_event;
    trap_set[BIT_DMA] = dma_fault_event;
    trap_set[BIT_MATH] = any_math_trap;
  end

  // writing 0 clears a flag, writing 1 leaves it; a same-cycle event wins
  always_comb begin
    next_trap_ctl = trap_ctl;
    if (wr_trap) begin
      next_trap_ctl = (reg_wdata & TRAP_CTRL_MASK) | (trap_ctl & reg_wdata & TRAP_FLAG_MASK);
    end
    next_trap_ctl = next_trap_ctl | trap_set;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      trap_ctl <= RST_TRAP;
    end else begin
      trap_ctl <= next_trap_ctl;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      math_trap <= 1'b0;
    end else begin
      math_trap <= any_math_trap;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      dma_trap <= 1'b0;
    end else begin
      dma_trap <= dma_fault_event;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // user source levels and selection

  logic [PRIO_LEVEL_W-1:0] src_prio [NUM_SRC];

  cpt_arb_if #(.NUM_SRC(NUM_SRC)) arb_bus ();

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++) begin : gen_src
      always_ff @(posedge clk) begin
        if (reset) begin
          src_prio[g] <= RST_SRC_PRIO;
        end else if (reg_wr && reg_hit(reg_addr, prio_ofs(g))) begin
          src_prio[g] <= reg_wdata[PRIO_LEVEL_W-1:0];
        end
      end
      assign arb_bus.prio_flat[PRIO_LEVEL_W*g +: PRIO_LEVEL_W] = src_prio[g];
    end
  endgenerate

  assign arb_bus.pending = user_irq_pending;

  cpt_src_arbiter #(.NUM_SRC(NUM_SRC)) u_arbiter (
    .a(arb_bus.arb)
  );

  logic take_now;
  // a level-7 field reads as "all user interrupts masked" by the same compare
  assign take_now = arb_bus.best_valid
    && ({1'b0, arb_bus.best_level} > eff_priority)
    && !cpu_priority_high_bit
    && !(nest_dis && core_in_service);

  // request stays up while the winning source is still eligible; the core
  // acknowledges by clearing the source's pending line and loading priority
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_take <= 1'b0;
    end else begin
      irq_take <= take_now;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_take_id <= '0;
    end else begin
      irq_take_id <= take_now ? arb_bus.best_id : '0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq_take_level <= '0;
    end else begin
      irq_take_level <= take_now ? arb_bus.best_level : '0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      cpu_priority <= '0;
      nesting_disable <= 1'b0;
    end else begin
      cpu_priority <= {next_high_preview(), next_low_preview()};
      nesting_disable <= next_trap_ctl[BIT_NEST_DIS];
    end
  end

  // outputs track the priority registers with no extra cycle of lag
  function automatic logic next_high_preview();
    if (core_priority_load) begin
      next_high_preview = core_priority_value[CPU_PRIO_W-1];
    end else if (wr_core && !reg_wdata[BIT_PRIO_HIGH]) begin
      next_high_preview = 1'b0;
    end else begin
      next_high_preview = cpu_priority_high_bit;
    end
  endfunction

  function automatic logic [PRIO_LEVEL_W-1:0] next_low_preview();
    if (core_priority_load) begin
      next_low_preview = core_priority_value[PRIO_LEVEL_W-1:0];
    end else if (wr_status && !nest_dis) begin
      next_low_preview = reg_wdata[BIT_PRIO_LOW +: PRIO_LEVEL_W];
    end else begin
      next_low_preview = cpu_priority_low;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // event status, mask and interrupt line

  logic [EVT_W-1:0] evt_status;
  logic [EVT_W-1:0] evt_mask;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] next_evt_status;
  logic [EVT_W-1:0] next_evt_mask;

  always_comb begin
    evt_set = '0;
    evt_set[EVT_MATH] = any_math_trap;
    evt_set[EVT_DMA] = dma_fault_event;
    next_evt_status = evt_status;
    if (wr_evt_status) begin
      next_evt_status = evt_status & ~reg_wdata[EVT_W-1:0];
    end
    next_evt_status = next_evt_status | evt_set;
    next_evt_mask = wr_evt_mask ? reg_wdata[EVT_W-1:0] : evt_mask;
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      evt_status <= RST_EVT;
    end else begin
      evt_status <= next_evt_status;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      evt_mask <= RST_EVT;
    end else begin
      evt_mask <= next_evt_mask;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_evt_status & next_evt_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read back

  logic [DATA_W-1:0] rd_value;

  // arithmetic flags of the status word live elsewhere and read as zero here
  always_comb begin
    rd_value = '0;
    if (reg_hit(reg_addr, OFS_STATUS)) begin
      rd_value[BIT_PRIO_LOW +: PRIO_LEVEL_W] = cpu_priority_low;
    end else if (reg_hit(reg_addr, OFS_CORE)) begin
      rd_value[BIT_PRIO_HIGH] = cpu_priority_high_bit;
    end else if (reg_hit(reg_addr, OFS_TRAP)) begin
      rd_value = trap_ctl;
    end else if (reg_hit(reg_addr, OFS_EVT_STATUS)) begin
      rd_value[EVT_W-1:0] = evt_status;
    end else if (reg_hit(reg_addr, OFS_EVT_MASK)) begin
      rd_value[EVT_W-1:0] = evt_mask;
    end else begin
      for (int i = 0; i < NUM_SRC; i++) begin
        if (reg_hit(reg_addr, prio_ofs(i))) begin
          rd_value[PRIO_LEVEL_W-1:0] = src_prio[i];
        end
      end
    end
  end

  // data stand only in the cycle after the read strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= RST_RDATA;
    end else begin
      reg_rdata <= reg_rd ? rd_value : RST_RDATA;
    end
  end

endmodule

// ### verif/cpt_priority_trap_sva.sv
`timescale 1ns/1ps
module cpt_priority_trap_sva
  import cpt_pkg::*;
#(
  parameter int NUM_SRC = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata,
  input wire logic core_priority_load,
  input wire logic core_in_service,
  input wire logic acc_a_overflow,
  input wire logic acc_b_overflow,
  input wire logic acc_a_catastrophic,
  input wire logic acc_b_catastrophic,
  input wire logic bad_shift_event,
  input wire logic divide_zero_event,
  input wire logic dma_fault_event,
  input wire logic [CPU_PRIO_W-1:0] cpu_priority,
  input wire logic nesting_disable,
  input wire logic irq_take,
  input wire logic [PRIO_LEVEL_W-1:0] irq_take_level,
  input wire logic math_trap,
  input wire logic dma_trap
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // a core load in the same cycle overrides software, so it is excluded
  sequence s_status_wr;
    reg_wr && reg_addr == OFS_STATUS && !core_priority_load;
  endsequence
  sequence s_held_service;
    nesting_disable && core_in_service ##1 nesting_disable && core_in_service;
  endsequence
  property p_prio_write;
    s_status_wr ##0 !nesting_disable |=> cpu_priority[2:0] == $past(reg_wdata[7:5]);
  endproperty
  property p_prio_locked;
    s_status_wr ##0 nesting_disable |=> cpu_priority == $past(cpu_priority);
  endproperty
  property p_high_rise;
    $rose(cpu_priority[3]) |-> $past(core_priority_load);
  endproperty
  property p_high_block;
    cpu_priority[3] && $stable(cpu_priority) |-> !irq_take;
  endproperty
  property p_take_above;
    irq_take && $stable(cpu_priority) |-> {1'b0, irq_take_level} > cpu_priority;
  endproperty
  property p_no_nest;
    s_held_service |-> !irq_take;
  endproperty
  property p_shift_div;
    bad_shift_event || divide_zero_event |=> math_trap;
  endproperty
  property p_dma;
    dma_fault_event |=> dma_trap ##1 (dma_trap == $past(dma_fault_event));
  endproperty
  property p_math_cause;
    math_trap |-> $past(acc_a_overflow || acc_b_overflow || acc_a_catastrophic || acc_b_catastrophic
      || bad_shift_event || divide_zero_event);
  endproperty
  property p_rdata;
    reg_rdata != 16'h0000 |-> $past(reg_rd);
  endproperty
  a_prio_write: assert property (p_prio_write)
    else $error("priority field not written");
  a_prio_locked: assert property (p_prio_locked)
    else $error("priority changed while locked");
  a_high_rise: assert property (p_high_rise)
    else $error("high priority bit set by software");
  a_high_block: assert property (p_high_block)
    else $error("user interrupt taken above level 7");
  a_take_above: assert property (p_take_above)
    else $error("taken level not above cpu priority");
  a_no_nest: assert property (p_no_nest)
    else $error("nested take while nesting disabled");
  a_shift_div: assert property (p_shift_div)
    else $error("math trap missing");
  a_dma: assert property (p_dma)
    else $error("dma trap pulse wrong");
  a_math_cause: assert property (p_math_cause)
    else $error("math trap without cause");
  a_rdata: assert property (p_rdata)
    else $error("read data outside read slot");
endmodule

// ### verif/cpt_core_model.sv
`timescale 1ns/1ps
// stands in for the processor core; events are {dma,div0,shift,catB,catA,ovfB,ovfA}
module cpt_core_model (
  input wire logic clk,
  output logic core_priority_load,
  output logic [3:0] core_priority_value,
  output logic core_in_service,
  output logic acc_a_overflow,
  output logic acc_b_overflow,
  output logic acc_a_catastrophic,
  output logic acc_b_catastrophic,
  output logic bad_shift_event,
  output logic divide_zero_event,
  output logic dma_fault_event
);
  logic [6:0] events;
  assign {dma_fault_event, divide_zero_event, bad_shift_event, acc_b_catastrophic, acc_a_catastrophic,
    acc_b_overflow, acc_a_overflow} = events;
  initial begin
    core_priority_load = 1'b0;
    core_priority_value = 4'h5;
    core_in_service = 1'b0;
    events = 7'h00;
  end
  task automatic fire(input logic [6:0] ev);
    @(posedge clk);
    events <= ev;
    @(posedge clk);
    events <= 7'h00;
  endtask
  task automatic load(input logic [3:0] v);
    @(posedge clk);
    core_priority_load <= 1'b1;
    core_priority_value <= v;
    @(posedge clk);
    core_priority_load <= 1'b0;
    // stale value inverted so a design that ignores the strobe shows it
    core_priority_value <= ~v;
  endtask
  task automatic serve(input logic on);
    @(posedge clk);
    core_in_service <= on;
  endtask
endmodule

// ### verif/cpt_priority_trap_bench.sv
`timescale 1ns/1ps
bind cpt_priority_trap cpt_priority_trap_sva #(.NUM_SRC(NUM_SRC)) u_sva (.clk(clk), .reset(reset),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .core_priority_load(core_priority_load), .core_in_service(core_in_service),
  .acc_a_overflow(acc_a_overflow), .acc_b_overflow(acc_b_overflow), .acc_a_catastrophic(acc_a_catastrophic),
  .acc_b_catastrophic(acc_b_catastrophic), .bad_shift_event(bad_shift_event),
  .divide_zero_event(divide_zero_event), .dma_fault_event(dma_fault_event), .cpu_priority(cpu_priority),
  .nesting_disable(nesting_disable), .irq_take(irq_take), .irq_take_level(irq_take_level),
  .math_trap(math_trap), .dma_trap(dma_trap));
module cpt_priority_trap_bench;
  import cpt_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] user_irq_pending = 8'h00;
  logic [15:0] reg_rdata;
  logic [3:0] cpu_priority;
  logic [2:0] irq_take_id;
  logic [2:0] irq_take_level;
  logic [3:0] prio_value;
  logic ovf_a, ovf_b, cat_a, cat_b, shift_ev, div0_ev, dma_ev;
  logic prio_load, in_service, nesting_disable, irq_take, math_trap, dma_trap, irq;
  int mismatches = 0;
  int check_count = 0;
  localparam logic [15:0] TEN [9] = '{16'h0400, 16'h0200, 16'h0100, 16'h0100, 16'h0000, 16'h0600, 16'h0000,
    16'h0000, 16'h0000};
  localparam logic [6:0] TEV [9] = '{7'h01, 7'h02, 7'h04, 7'h08, 7'h01, 7'h0C, 7'h10, 7'h20, 7'h40};
  localparam logic [15:0] TFL [9] = '{16'h4410, 16'h2210, 16'h1110, 16'h0910, 16'h0000, 16'h0600, 16'h0090,
    16'h0050, 16'h0020};
  localparam logic [1:0] TPU [9] = '{2'h1, 2'h1, 2'h1, 2'h1, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2};
  always #4 clk = ~clk;
  cpt_core_model core (.clk(clk), .core_priority_load(prio_load), .core_priority_value(prio_value),
    .core_in_service(in_service), .acc_a_overflow(ovf_a), .acc_b_overflow(ovf_b), .acc_a_catastrophic(cat_a),
    .acc_b_catastrophic(cat_b), .bad_shift_event(shift_ev), .divide_zero_event(div0_ev),
    .dma_fault_event(dma_ev));
  cpt_priority_trap dut (.clk(clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_priority_load(prio_load),
    .core_priority_value(prio_value), .core_in_service(in_service), .acc_a_overflow(ovf_a),
    .acc_b_overflow(ovf_b), .acc_a_catastrophic(cat_a), .acc_b_catastrophic(cat_b), .bad_shift_event(shift_ev),
    .divide_zero_event(div0_ev), .dma_fault_event(dma_ev), .user_irq_pending(user_irq_pending),
    .cpu_priority(cpu_priority), .nesting_disable(nesting_disable), .irq_take(irq_take),
    .irq_take_id(irq_take_id), .irq_take_level(irq_take_level), .math_trap(math_trap), .dma_trap(dma_trap),
    .irq(irq));
  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask
  function automatic logic [15:0] take_vec();
    return {8'h00, irq_take, irq_take_id, 1'b0, irq_take_level};
  endfunction
  ////////////////////////////////////////////////////////////////
  task automatic t_reset;
    chk({12'h000, cpu_priority}, 16'h0000);
    rd(OFS_STATUS, 16'h0000);
    rd(OFS_CORE, 16'h0000);
    rd(OFS_TRAP, 16'h0000);
    wr(8'h0E, 16'hFFFF);
    rd(8'h0E, 16'h0000);
  endtask
  task automatic t_prio;
    for (int v = 0; v < 8; v++) begin
      wr(OFS_STATUS, 16'(v << 5));
      rd(OFS_STATUS, 16'(v << 5));
      chk({12'h000, cpu_priority}, 16'(v));
    end
  endtask
  task automatic t_take;
    wr(OFS_PRIO_BASE + 8'h02, 16'h0005);
    wr(OFS_PRIO_BASE + 8'h04, 16'h0007);
    wr(OFS_STATUS, 16'h0040);
    user_irq_pending <= 8'h07;
    wr(OFS_CORE, 16'h0008);
    tick(2);
    chk({12'h000, cpu_priority}, 16'h0002);
    chk(take_vec(), 16'h00A7);
    core.load(4'hA);
    tick(2);
    chk({12'h000, cpu_priority}, 16'h000A);
    chk(take_vec(), 16'h0000);
    rd(OFS_CORE, 16'h0008);
    wr(OFS_CORE, 16'h0000);
    tick(2);
    chk({12'h000, cpu_priority}, 16'h0002);
    core.load(4'h7);
    tick(2);
    chk(take_vec(), 16'h0000);
    // level-0 source 0 must stay out even at the lowest cpu priority
    user_irq_pending <= 8'h01;
    core.load(4'h0);
    tick(2);
    chk(take_vec(), 16'h0000);
  endtask
  task automatic t_nest;
    wr(OFS_STATUS, 16'h0040);
    user_irq_pending <= 8'h04;
    core.serve(1'b1);
    tick(2);
    chk(take_vec(), 16'h00A7);
    wr(OFS_TRAP, 16'h8000);
    #1;
    chk({15'h0000, nesting_disable}, 16'h0001);
    wr(OFS_STATUS, 16'h00E0);
    rd(OFS_STATUS, 16'h0040);
    chk(take_vec(), 16'h0000);
    core.serve(1'b0);
    tick(2);
    chk(take_vec(), 16'h00A7);
    wr(OFS_TRAP, 16'h0000);
    #1;
    chk({15'h0000, nesting_disable}, 16'h0000);
    user_irq_pending <= 8'h00;
  endtask
  task automatic t_traps;
    for (int i = 0; i < 9; i++) begin
      wr(OFS_TRAP, TEN[i]);
      core.fire(TEV[i]);
      #1;
      chk({14'h0000, dma_trap, math_trap}, {14'h0000, TPU[i]});
      tick(3);
      rd(OFS_TRAP, TFL[i]);
      wr(OFS_TRAP, 16'h0000);
    end
    wr(OFS_TRAP, 16'h78F0);
    rd(OFS_TRAP, 16'h0000);
  endtask
  task automatic t_irq;
    wr(OFS_EVT_STATUS, 16'h0003);
    wr(OFS_EVT_MASK, 16'h0001);
    core.fire(7'h20);
    tick(2);
    chk({15'h0000, irq}, 16'h0001);
    core.fire(7'h40);
    tick(2);
    rd(OFS_EVT_STATUS, 16'h0003);
    wr(OFS_EVT_STATUS, 16'h0001);
    tick(1);
    chk({15'h0000, irq}, 16'h0000);
    wr(OFS_EVT_MASK, 16'h0002);
    tick(1);
    chk({15'h0000, irq}, 16'h0001);
    wr(OFS_EVT_STATUS, 16'h0002);
    tick(1);
    chk({15'h0000, irq}, 16'h0000);
    rd(OFS_TRAP, 16'h0070);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_prio();
    t_take();
    t_nest();
    t_traps();
    t_irq();
    give_verdict();
  end
  // the whole run needs well under 2000 cycles
  initial begin
    #100000;
    mismatches++;
    $display("ERROR %0t: watchdog expired", $time);
    give_verdict();
  end
endmodule
